/* verilog/tbvr_pkg.sv */
// Package for the translation base and virtual error register bank.
// Assumes a 32-bit APB master; each 64-bit register except the deferred status is split into two words.
package tbvr_pkg;
   localparam int unsigned APB_AW = 8;
   // Byte offsets, low word then high word.
   localparam logic [7:0] OFF_HWC_LO  = 8'h00;
   localparam logic [7:0] OFF_HWC_HI  = 8'h04;
   localparam logic [7:0] OFF_MWC     = 8'h08;
   localparam logic [7:0] OFF_KTB0_LO = 8'h10;
   localparam logic [7:0] OFF_KTB0_HI = 8'h14;
   localparam logic [7:0] OFF_HTB0_LO = 8'h18;
   localparam logic [7:0] OFF_HTB0_HI = 8'h1c;
   localparam logic [7:0] OFF_MTB0_LO = 8'h20;
   localparam logic [7:0] OFF_MTB0_HI = 8'h24;
   localparam logic [7:0] OFF_KTB1_LO = 8'h28;
   localparam logic [7:0] OFF_KTB1_HI = 8'h2c;
   localparam logic [7:0] OFF_HTB1_LO = 8'h30;
   localparam logic [7:0] OFF_HTB1_HI = 8'h34;
   localparam logic [7:0] OFF_VDES    = 8'h38;
   localparam logic [7:0] OFF_VES     = 8'h40;
   localparam logic [7:0] OFF_KWC_LO  = 8'h48;
   localparam logic [7:0] OFF_KWC_HI  = 8'h4c;
   localparam logic [7:0] OFF_HCFG    = 8'h50;
   localparam logic [7:0] OFF_STAT    = 8'h54;
   // Field positions.
   localparam int unsigned DIRTY_BIT   = 22;
   localparam int unsigned AFLAG_BIT   = 21;
   localparam int unsigned KDIRTY_BIT  = 40;
   localparam int unsigned KAFLAG_BIT  = 39;
   localparam int unsigned SEL_BIT     = 22;
   localparam logic [31:0] ARCH_MASK   = 32'h1fe0_0000;
   localparam logic [31:0] HI_IDENT_MSK = 32'hffff_0000;
   localparam logic [31:0] HI_ADDR_MSK = 32'h0000_ffff;
   localparam logic [31:0] SYN_MASK    = 32'h01ff_ffff;
   localparam int unsigned TYPE_FLAG_BIT = 24;
   localparam int unsigned XLOW_W      = 6;
   localparam int unsigned HOST_MODE_BIT = 0;
   localparam int unsigned VREQ_BIT      = 1;
   // Deferred status bit that marks a record taken by a barrier.
   localparam int unsigned REC_FLAG_BIT  = 25;
   localparam logic [31:0] ZERO32      = 32'h0000_0000;

   typedef struct packed {
      logic        dirty_update_enable;
      logic        access_flag_update_enable;
   } tbvr_walk_t;

   typedef struct packed {
      logic [15:0] address_space_identifier;
      logic [46:0] table_base_address;
      logic        common_translation_flag;
   } tbvr_base_t;
endpackage

/* verilog/tbvr_regs.sv */
// Register bank holding stage 1 walk controls, table bases and the virtual
// error syndrome. Assumes an APB master on clk_i and a walker and exception
// unit that consume the derived outputs.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Bit 22 of the EL2 and EL3 walk controls enables hardware dirty update.
// - Bit 21 of the EL2 and EL3 walk controls enables access flag update.
// - Bits 28 to 21 of both walk controls are stored and read back.
// - The EL3 walk control is 32 bits wide and the EL2 one 64 bits wide.
// - In host extension mode the EL2 walk control uses the EL1 layout.
// - EL1 bases hold an identifier in bits 63 to 48, chosen by a selector.
// - Every base holds the table base address in bits 47 to 1.
// - The walker sees base bits below x as zero when misaligned.
// - Reads of base bits below x return what software wrote.
// - Bit 0 of every base is the common translation flag.
// - In host extension mode EL2 base zero keeps an identifier as EL1 does.
// - EL2 base one has the same format as EL1 base one.
// - A virtual error taken to EL1 loads syndrome bit 24 from the type flag.
// - A virtual error taken to EL1 loads syndrome bits 23 to 0 from the field.
// - The deferred status records a virtual error consumed by a barrier.
// - The deferred status captures the stored type flag and syndrome bits.
module tbvr_regs #(
   parameter int unsigned X_DEFAULT = 12
) (
   input  wire logic                         clk_i,
   input  wire logic                         srst_i,
   input  wire logic                         psel_i,
   input  wire logic                         penable_i,
   input  wire logic                         pwrite_i,
   input  wire logic [tbvr_pkg::APB_AW-1:0]  paddr_i,
   input  wire logic [31:0]                  pwdata_i,
   input  wire logic [3:0]                   pstrb_i,
   input  wire logic [5:0]                   align_x_i,
   input  wire logic                         error_sync_barrier_i,
   input  wire logic                         verr_take_i,
   output logic                              pready_o,
   output logic                              pslverr_o,
   output logic [31:0]                       prdata_o,
   output tbvr_pkg::tbvr_walk_t              hyp_walk_o,
   output tbvr_pkg::tbvr_walk_t              mon_walk_o,
   output tbvr_pkg::tbvr_base_t              kern_base0_o,
   output tbvr_pkg::tbvr_base_t              kern_base1_o,
   output tbvr_pkg::tbvr_base_t              hyp_base0_o,
   output tbvr_pkg::tbvr_base_t              mon_base0_o,
   output logic [15:0]                       active_address_space_identifier_o,
   output logic                              syn_load_o,
   output logic [24:0]                       kernel_exception_syndrome_o
);

   ////////////////////////////////////////////////////////////////////////
   logic [63:0] hwc_r, kwc_r, ktb0_r, ktb1_r, htb0_r, htb1_r, mtb0_r, vdes_r;
   logic [31:0] mwc_r, ves_r, hcfg_r;
   logic        wr_en, rd_en, hit;
   logic [31:0] rdata_nxt;
   logic        host_mode;

   assign wr_en     = psel_i & penable_i & pwrite_i & ~pready_o;
   assign rd_en     = psel_i & penable_i & ~pwrite_i & ~pready_o;
   assign host_mode = hcfg_r[tbvr_pkg::HOST_MODE_BIT];

   // Byte-lane merge of a write into a held word under a writable mask.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  strb,
                                         input logic [31:0] msk);
      logic [31:0] lane;
      lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & msk;
      return (old & ~lane) | (wd & lane);
   endfunction

   // Base address as the walker uses it: bits below x forced to zero.
   function automatic tbvr_pkg::tbvr_base_t walk_view(input logic [63:0] r,
                                                      input logic [5:0]  x,
                                                      input logic        keep_id);
      tbvr_pkg::tbvr_base_t b;
      logic [63:0] m;
      m = ~((64'h1 << x) - 64'h1);
      b.address_space_identifier = keep_id ? r[63:48] : 16'h0000;
      b.table_base_address       = r[47:1] & m[47:1];
      b.common_translation_flag  = r[0];
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Writes. The EL2 walk control takes the full EL1 layout only in host mode.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hwc_r <= 64'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_HWC_LO) begin
         hwc_r[31:0] <= merge(hwc_r[31:0], pwdata_i, pstrb_i,
                              host_mode ? ~tbvr_pkg::ZERO32 : tbvr_pkg::ARCH_MASK);
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_HWC_HI && host_mode) begin
         hwc_r[63:32] <= merge(hwc_r[63:32], pwdata_i, pstrb_i, ~tbvr_pkg::ZERO32);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mwc_r <= 32'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_MWC) begin
         mwc_r <= merge(mwc_r, pwdata_i, pstrb_i, tbvr_pkg::ARCH_MASK);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         kwc_r <= 64'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_KWC_LO) begin
         kwc_r[31:0] <= merge(kwc_r[31:0], pwdata_i, pstrb_i, ~tbvr_pkg::ZERO32);
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_KWC_HI) begin
         kwc_r[63:32] <= merge(kwc_r[63:32], pwdata_i, pstrb_i, ~tbvr_pkg::ZERO32);
      end
   end

   // Base address bits are stored exactly as written so misaligned low bits read back.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ktb0_r <= 64'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_KTB0_LO) begin
         ktb0_r[31:0] <= merge(ktb0_r[31:0], pwdata_i, pstrb_i,
                               ~tbvr_pkg::ZERO32);
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_KTB0_HI) begin
         ktb0_r[63:32] <= merge(ktb0_r[63:32], pwdata_i, pstrb_i,
                                ~tbvr_pkg::ZERO32);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ktb1_r <= 64'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_KTB1_LO) begin
         ktb1_r[31:0] <= merge(ktb1_r[31:0], pwdata_i, pstrb_i,
                               ~tbvr_pkg::ZERO32);
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_KTB1_HI) begin
         ktb1_r[63:32] <= merge(ktb1_r[63:32], pwdata_i, pstrb_i,
                                ~tbvr_pkg::ZERO32);
      end
   end

   // EL2 base one shares the EL1 base one layout, identifier included.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         htb1_r <= 64'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_HTB1_LO) begin
         htb1_r[31:0] <= merge(htb1_r[31:0], pwdata_i, pstrb_i,
                               ~tbvr_pkg::ZERO32);
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_HTB1_HI) begin
         htb1_r[63:32] <= merge(htb1_r[63:32], pwdata_i, pstrb_i,
                                ~tbvr_pkg::ZERO32);
      end
   end

   // The EL3 base has no identifier, so its top half keeps only address bits.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mtb0_r <= 64'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_MTB0_LO) begin
         mtb0_r[31:0] <= merge(mtb0_r[31:0], pwdata_i, pstrb_i,
                               ~tbvr_pkg::ZERO32);
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_MTB0_HI) begin
         mtb0_r[63:32] <= merge(mtb0_r[63:32], pwdata_i, pstrb_i,
                                tbvr_pkg::HI_ADDR_MSK);
      end
   end

   // The identifier half of EL2 base zero is writable only in host mode.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         htb0_r <= 64'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_HTB0_LO) begin
         htb0_r[31:0] <= merge(htb0_r[31:0], pwdata_i, pstrb_i, ~tbvr_pkg::ZERO32);
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_HTB0_HI) begin
         htb0_r[63:32] <= merge(htb0_r[63:32], pwdata_i, pstrb_i,
                                host_mode ? ~tbvr_pkg::ZERO32
                                          : tbvr_pkg::HI_ADDR_MSK);
      end
   end

   // Only the type flag and syndrome bits are kept; the rest reads as zero.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ves_r <= 32'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_VES) begin
         ves_r <= merge(ves_r, pwdata_i, pstrb_i, tbvr_pkg::SYN_MASK);
      end
   end

   // Bit 0 selects host extension mode and bit 1 raises the virtual error request.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hcfg_r <= 32'h0;
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_HCFG) begin
         hcfg_r <= merge(hcfg_r, pwdata_i, pstrb_i, ~tbvr_pkg::ZERO32);
      end
   end

   // A barrier with the virtual error request set wins over a software write in the same cycle. The record
   // flag is set by a barrier, and a write to the low word can also set or clear it.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         vdes_r <= 64'h0;
      end else if (error_sync_barrier_i && hcfg_r[tbvr_pkg::VREQ_BIT]) begin
         vdes_r <= {38'h0, 1'b1, ves_r[tbvr_pkg::TYPE_FLAG_BIT:0]};
      end else if (wr_en && paddr_i == tbvr_pkg::OFF_VDES) begin
         vdes_r[31:0] <= merge(vdes_r[31:0], pwdata_i, pstrb_i, ~tbvr_pkg::ZERO32);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      hit = 1'b1;
      unique case (paddr_i)
         tbvr_pkg::OFF_HWC_LO:  rdata_nxt = hwc_r[31:0];
         tbvr_pkg::OFF_HWC_HI:  rdata_nxt = hwc_r[63:32];
         tbvr_pkg::OFF_MWC:     rdata_nxt = mwc_r;
         tbvr_pkg::OFF_KWC_LO:  rdata_nxt = kwc_r[31:0];
         tbvr_pkg::OFF_KWC_HI:  rdata_nxt = kwc_r[63:32];
         tbvr_pkg::OFF_KTB0_LO: rdata_nxt = ktb0_r[31:0];
         tbvr_pkg::OFF_KTB0_HI: rdata_nxt = ktb0_r[63:32];
         tbvr_pkg::OFF_KTB1_LO: rdata_nxt = ktb1_r[31:0];
         tbvr_pkg::OFF_KTB1_HI: rdata_nxt = ktb1_r[63:32];
         tbvr_pkg::OFF_HTB0_LO: rdata_nxt = htb0_r[31:0];
         tbvr_pkg::OFF_HTB0_HI: rdata_nxt = host_mode ? htb0_r[63:32]
                                          : htb0_r[63:32] & tbvr_pkg::HI_ADDR_MSK;
         tbvr_pkg::OFF_HTB1_LO: rdata_nxt = htb1_r[31:0];
         tbvr_pkg::OFF_HTB1_HI: rdata_nxt = htb1_r[63:32];
         tbvr_pkg::OFF_MTB0_LO: rdata_nxt = mtb0_r[31:0];
         tbvr_pkg::OFF_MTB0_HI: rdata_nxt = mtb0_r[63:32];
         tbvr_pkg::OFF_VDES:    rdata_nxt = vdes_r[31:0];
         tbvr_pkg::OFF_VES:     rdata_nxt = ves_r;
         tbvr_pkg::OFF_HCFG:    rdata_nxt = hcfg_r;
         tbvr_pkg::OFF_STAT:    rdata_nxt = {31'h0, vdes_r[tbvr_pkg::REC_FLAG_BIT]};
         default: begin
            rdata_nxt = tbvr_pkg::ZERO32;
            hit       = 1'b0;
         end
      endcase
   end

   // One wait state: the answer comes in the second access cycle.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0;
      end else begin
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
         prdata_o  <= rd_en ? rdata_nxt : tbvr_pkg::ZERO32;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // In host mode the EL2 walk flags move to the EL1 positions.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hyp_walk_o <= '0;
      end else if (host_mode) begin
         hyp_walk_o.dirty_update_enable       <= hwc_r[tbvr_pkg::KDIRTY_BIT];
         hyp_walk_o.access_flag_update_enable <= hwc_r[tbvr_pkg::KAFLAG_BIT];
      end else begin
         hyp_walk_o.dirty_update_enable       <= hwc_r[tbvr_pkg::DIRTY_BIT];
         hyp_walk_o.access_flag_update_enable <= hwc_r[tbvr_pkg::AFLAG_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mon_walk_o <= '0;
      end else begin
         mon_walk_o.dirty_update_enable       <= mwc_r[tbvr_pkg::DIRTY_BIT];
         mon_walk_o.access_flag_update_enable <= mwc_r[tbvr_pkg::AFLAG_BIT];
      end
   end

   // The walker view lags a change of the alignment exponent by one cycle.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         kern_base0_o <= '0;
         kern_base1_o <= '0;
         hyp_base0_o  <= '0;
         mon_base0_o  <= '0;
      end else begin
         kern_base0_o <= walk_view(ktb0_r, align_x_i, 1'b1);
         kern_base1_o <= walk_view(ktb1_r, align_x_i, 1'b1);
         hyp_base0_o  <= walk_view(htb0_r, align_x_i, host_mode);
         mon_base0_o  <= walk_view(mtb0_r, align_x_i, 1'b0);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         active_address_space_identifier_o <= 16'h0;
      end else begin
         active_address_space_identifier_o <= kwc_r[tbvr_pkg::SEL_BIT] ? ktb1_r[63:48] : ktb0_r[63:48];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         syn_load_o                  <= 1'b0;
         kernel_exception_syndrome_o <= 25'h0;
      end else begin
         syn_load_o <= verr_take_i & hcfg_r[tbvr_pkg::VREQ_BIT];
         if (verr_take_i && hcfg_r[tbvr_pkg::VREQ_BIT]) begin
            kernel_exception_syndrome_o <= {ves_r[tbvr_pkg::TYPE_FLAG_BIT],
                                            ves_r[23:0]};
         end
      end
   end

endmodule // tbvr_regs

/* bench/tbvr_regs_checker.sv */
// Port checks for the register bank: handshake, walk flags, alignment, syndrome.
// Assumes it is bound to tbvr_regs, one clock and a synchronous reset.
`timescale 1ns/1ps
module tbvr_regs_checker (
   input wire logic                 clk_i,
   input wire logic                 srst_i,
   input wire logic                 psel_i,
   input wire logic                 penable_i,
   input wire logic                 pwrite_i,
   input wire logic [7:0]           paddr_i,
   input wire logic [31:0]          pwdata_i,
   input wire logic [5:0]           align_x_i,
   input wire logic                 verr_take_i,
   input wire logic                 pready_o,
   input wire logic                 pslverr_o,
   input wire logic [31:0]          prdata_o,
   input wire tbvr_pkg::tbvr_walk_t mon_walk_o,
   input wire tbvr_pkg::tbvr_base_t kern_base0_o,
   input wire logic                 syn_load_o,
   input wire logic [24:0]          kernel_exception_syndrome_o
);
   logic [1:0]  wr_walk;
   logic [46:0] low_mask;
   logic        acc;
   assign wr_walk = pwdata_i[22:21];
   assign acc = psel_i && penable_i && !pready_o;
   // The mask is registered because the walker view lags the exponent by one cycle.
   always_ff @(posedge clk_i) begin
      low_mask <= (align_x_i == 6'd0) ? 47'h0 : ((47'h1 << (align_x_i - 6'd1)) - 47'h1);
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   AST_READY_ONE: assert property (acc |=> pready_o)
      else $error("access not answered after one wait cycle");
   AST_READY_PULSE: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   AST_READY_IDLE: assert property (!(psel_i && penable_i) |=> !pready_o)
      else $error("ready without an access phase");
   AST_ERR_READY: assert property (pslverr_o |-> pready_o)
      else $error("error flag outside the answer cycle");
   AST_RDATA_IDLE: assert property ((!pready_o || pwrite_i) |-> prdata_o == 32'h0)
      else $error("read data not zero outside a read answer");
   AST_MON_WALK: assert property (
      acc && pwrite_i && paddr_i == tbvr_pkg::OFF_MWC |=> ##1 mon_walk_o == $past(wr_walk))
      else $error("monitor walk flags do not follow the write");
   AST_BASE_ALIGN: assert property (
      (kern_base0_o.table_base_address & low_mask) == 47'h0)
      else $error("walker sees base bits below the alignment");
   AST_SYN_CAUSE: assert property (syn_load_o |-> $past(verr_take_i))
      else $error("syndrome load without a taken error");
   AST_SYN_HOLD: assert property (
      $changed(kernel_exception_syndrome_o) && !$past(srst_i) |-> syn_load_o)
      else $error("syndrome changed without a load");
endmodule // tbvr_regs_checker

/* bench/tbvr_regs_tb.sv */
// Self-checking bench for the register bank, driven over APB.
// Assumes the package, tbvr_regs and its checker are compiled first.
`timescale 1ns/1ps
module tbvr_regs_tb;
   logic clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic error_sync_barrier_i = 1'b0, verr_take_i = 1'b0, pready_o, pslverr_o, syn_load_o, err;
   logic [7:0]           paddr_i = 8'h00;
   logic [31:0]          pwdata_i = 32'h0, prdata_o, rd;
   logic [3:0]           pstrb_i = 4'hf;
   logic [5:0]           align_x_i = 6'd12;
   logic [15:0]          active_address_space_identifier_o;
   logic [24:0]          kernel_exception_syndrome_o;
   tbvr_pkg::tbvr_walk_t hyp_walk_o, mon_walk_o;
   tbvr_pkg::tbvr_base_t kern_base0_o, kern_base1_o, hyp_base0_o, mon_base0_o;
   int                   failures = 0, tests_run = 0;

   tbvr_regs uut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .align_x_i(align_x_i), .error_sync_barrier_i(error_sync_barrier_i),
      .verr_take_i(verr_take_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .prdata_o(prdata_o), .hyp_walk_o(hyp_walk_o), .mon_walk_o(mon_walk_o),
      .kern_base0_o(kern_base0_o), .kern_base1_o(kern_base1_o), .hyp_base0_o(hyp_base0_o),
      .mon_base0_o(mon_base0_o), .active_address_space_identifier_o(active_address_space_identifier_o), .syn_load_o(syn_load_o),
      .kernel_exception_syndrome_o(kernel_exception_syndrome_o));

   always #50 clk_i = ~clk_i;
   ////////////////////////////////////////
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Entered just after a rising edge; one idle edge at the end keeps back-to-back calls clean.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check({err, rd}, {1'b0, exp});
   endtask

   task automatic pulse(input logic barrier);
      verr_take_i <= !barrier;
      error_sync_barrier_i <= barrier;
      @(posedge clk_i);
      verr_take_i <= 1'b0;
      error_sync_barrier_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic t_walks;
      logic [31:0] v [4] = '{32'hffff_ffff, 32'h0040_0000, 32'h0020_0000, 32'h0};
      foreach (v[i]) begin
         wr(tbvr_pkg::OFF_MWC, v[i]);
         check(mon_walk_o, v[i][22:21]);
         rdchk(tbvr_pkg::OFF_MWC, v[i] & tbvr_pkg::ARCH_MASK);
      end
      wr(tbvr_pkg::OFF_HWC_LO, 32'hffff_ffff);
      wr(tbvr_pkg::OFF_HWC_HI, 32'hffff_ffff);
      check(hyp_walk_o, 2'b11);
      rdchk(tbvr_pkg::OFF_HWC_LO, tbvr_pkg::ARCH_MASK);
      rdchk(tbvr_pkg::OFF_HWC_HI, 32'h0);
      wr(tbvr_pkg::OFF_HWC_LO, 32'h0040_0000);
      check(hyp_walk_o, 2'b10);
      wr(tbvr_pkg::OFF_HCFG, 32'h1);
      wr(tbvr_pkg::OFF_HWC_HI, 32'h0000_0080);
      check(hyp_walk_o, 2'b01);
      rdchk(tbvr_pkg::OFF_HWC_HI, 32'h0000_0080);
      wr(tbvr_pkg::OFF_HCFG, 32'h0);
   endtask

   task automatic t_bases;
      wr(tbvr_pkg::OFF_KTB0_LO, 32'h0000_0fff);
      wr(tbvr_pkg::OFF_KTB0_HI, 32'habcd_1234);
      rdchk(tbvr_pkg::OFF_KTB0_LO, 32'h0000_0fff);
      rdchk(tbvr_pkg::OFF_KTB0_HI, 32'habcd_1234);
      check(kern_base0_o, {16'habcd, 16'h1234, 31'h0, 1'b1});
      align_x_i <= 6'd4;
      repeat (2) @(posedge clk_i);
      check(kern_base0_o, {16'habcd, 16'h1234, 31'h7f8, 1'b1});
      wr(tbvr_pkg::OFF_MTB0_HI, 32'hffff_ffff);
      rdchk(tbvr_pkg::OFF_MTB0_HI, 32'h0000_ffff);
      check(mon_base0_o, {32'h0000_ffff, 32'h0});
      wr(tbvr_pkg::OFF_HTB0_HI, 32'hffff_ffff);
      rdchk(tbvr_pkg::OFF_HTB0_HI, 32'h0000_ffff);
      check(hyp_base0_o, {32'h0000_ffff, 32'h0});
      wr(tbvr_pkg::OFF_HCFG, 32'h1);
      wr(tbvr_pkg::OFF_HTB0_HI, 32'hffff_ffff);
      rdchk(tbvr_pkg::OFF_HTB0_HI, 32'hffff_ffff);
      check(hyp_base0_o, {32'hffff_ffff, 32'h0});
      wr(tbvr_pkg::OFF_HTB1_HI, 32'h5a5a_1234);
      rdchk(tbvr_pkg::OFF_HTB1_HI, 32'h5a5a_1234);
   endtask

   task automatic t_select;
      wr(tbvr_pkg::OFF_KTB1_HI, 32'h5555_0000);
      wr(tbvr_pkg::OFF_KWC_LO, 32'h0040_0000);
      check(active_address_space_identifier_o, 16'h5555);
      check(kern_base1_o, {32'h5555_0000, 32'h0});
      wr(tbvr_pkg::OFF_KWC_LO, 32'h0);
      check(active_address_space_identifier_o, 16'habcd);
      pstrb_i <= 4'h2;
      wr(tbvr_pkg::OFF_KTB1_LO, 32'hffff_ffff);
      pstrb_i <= 4'hf;
      rdchk(tbvr_pkg::OFF_KTB1_LO, 32'h0000_ff00);
   endtask

   task automatic t_verr;
      wr(tbvr_pkg::OFF_VES, 32'hffff_ffff);
      rdchk(tbvr_pkg::OFF_VES, 32'h01ff_ffff);
      wr(tbvr_pkg::OFF_VES, 32'h0123_4566);
      wr(tbvr_pkg::OFF_HCFG, 32'h1);
      pulse(1'b0);
      check(syn_load_o, 1'b0);
      wr(tbvr_pkg::OFF_HCFG, 32'h3);
      pulse(1'b0);
      check({syn_load_o, kernel_exception_syndrome_o}, {1'b1, 25'h123_4566});
      rdchk(tbvr_pkg::OFF_STAT, 32'h0);
      pulse(1'b1);
      rdchk(tbvr_pkg::OFF_VDES, 32'h0323_4566);
      rdchk(tbvr_pkg::OFF_STAT, 32'h1);
   endtask

   task automatic t_unmapped;
      apb(1'b1, 8'h5c, 32'hffff_ffff);
      check(err, 1'b1);
      apb(1'b0, 8'h5c, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
   endtask

   task automatic final_report;
      if (failures == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      t_walks();
      t_bases();
      t_select();
      t_verr();
      t_unmapped();
      final_report();
   end

   // About 200 cycles are needed; the margin covers a stalled handshake.
   initial begin
      repeat (5000) @(posedge clk_i);
      failures++;
      final_report();
   end
endmodule // tbvr_regs_tb

bind tbvr_regs tbvr_regs_checker chk (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .align_x_i(align_x_i), .verr_take_i(verr_take_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .prdata_o(prdata_o), .mon_walk_o(mon_walk_o),
   .kern_base0_o(kern_base0_o), .syn_load_o(syn_load_o),
   .kernel_exception_syndrome_o(kernel_exception_syndrome_o));
